// [core/gocx_pkg.sv]
// Package: constants and carriers of the pin and crystal block
// How it works
// RL1 - Input codes 12-15 select control inputs
// RL2 - Output code 0 level, 1 slow clock
// RL3 - Codes 2-4 power state flags, 5-7 reserved
// RL4 - Codes 8,9 DVS done; 10,11 power enables
// RL5 - Code 12 supply good, 13 power good
// RL6 - Code 14 fast clock, 15 aux reset
// RL7 - Crystal enable bit 2 runs OFF/ON/SLEEP
// RL8 - BACKUP state uses crystal backup enable
// RL9 - Crystal enable written only during load
// RL10 - Inhibit clear: RC clock until crystal valid
// RL11 - Inhibit set: hold ON until crystal valid
// RL12 - Bit 15 direction, 1 is input
// RL13 - Bits 14:13 pull select, reset 01
// RL14 - Bit 12 picks rising or both edges
// RL15 - Polarity 0 inverted, 1 non-inverted
// RL16 - Drive enable 0 keeps pin tri-stated
// RL17 - Function code table chosen by direction
// RL18 - Crystal valid after stable start count
package gocx_pkg;

  // Register offsets (index; byte address is four times this)
  localparam logic [15:0] GOCX_IDX_PIN1 = 16'h781A;
  localparam logic [15:0] GOCX_IDX_PIN2 = 16'h781B;
  localparam logic [15:0] GOCX_IDX_STAT = 16'h781C;
  localparam logic [15:0] GOCX_IDX_MASK = 16'h781D;
  localparam logic [15:0] GOCX_IDX_CTRL = 16'h781E;
  localparam logic [15:0] GOCX_IDX_STATE = 16'h781F;

  // Field positions
  localparam int GOCX_POS_DIR = 15;
  localparam int GOCX_POS_PULL = 13;
  localparam int GOCX_POS_IRQM = 12;
  localparam int GOCX_POS_POL = 10;
  localparam int GOCX_POS_ENA = 8;
  localparam int GOCX_POS_FN = 4;
  localparam int GOCX_POS_XENA = 2;
  localparam int GOCX_POS_XINH = 1;
  localparam int GOCX_POS_BKUP = 0;

  // Reset values
  localparam logic [15:0] GOCX_RST_PIN = 16'hA400;
  localparam logic [2:0] GOCX_RST_XTAL = 3'h0;
  localparam logic [1:0] GOCX_PULL_DOWN = 2'h1;

  // Timing: slow clock 32.768 kHz, fast clock 2.5 MHz (2 MHz rounds to a 2-cycle half period), crystal settle 1 ms
  localparam int GOCX_CLK_HZ = 10000000;
  localparam int GOCX_FAST_HZ = 2000000;
  localparam int GOCX_FAST_HALF = GOCX_CLK_HZ / (2 * GOCX_FAST_HZ);
  localparam int GOCX_SLOW_HZ_X1000 = 32768000;
  localparam int GOCX_SLOW_HALF = (GOCX_CLK_HZ / 2) / (GOCX_SLOW_HZ_X1000 / 1000);
  localparam int GOCX_XTAL_SETTLE_US = 1000;
  localparam int GOCX_XTAL_SETTLE_CYC = (GOCX_XTAL_SETTLE_US * (GOCX_CLK_HZ / 1000000));

  // Power states
  typedef enum logic [1:0] {GOCX_ST_OFF, GOCX_ST_ON, GOCX_ST_SLEEP, GOCX_ST_BACKUP} gocx_pstate_type;

  // Output function codes
  localparam logic [3:0] GOCX_FN_LEVEL = 4'h0;
  localparam logic [3:0] GOCX_FN_SLOWCLK = 4'h1;
  localparam logic [3:0] GOCX_FN_ON = 4'h2;
  localparam logic [3:0] GOCX_FN_SLEEP = 4'h3;
  localparam logic [3:0] GOCX_FN_CHANGE = 4'h4;
  localparam logic [3:0] GOCX_FN_DVS1 = 4'h8;
  localparam logic [3:0] GOCX_FN_DVS2 = 4'h9;
  localparam logic [3:0] GOCX_FN_EPE1 = 4'hA;
  localparam logic [3:0] GOCX_FN_EPE2 = 4'hB;
  localparam logic [3:0] GOCX_FN_SYSGOOD = 4'hC;
  localparam logic [3:0] GOCX_FN_PWRGOOD = 4'hD;
  localparam logic [3:0] GOCX_FN_FASTCLK = 4'hE;
  localparam logic [3:0] GOCX_FN_AUXRST = 4'hF;

  // Input function codes that reach the control inputs
  localparam logic [3:0] GOCX_IN_HWC1 = 4'hC;
  localparam logic [3:0] GOCX_IN_HWC2 = 4'hD;
  localparam logic [3:0] GOCX_IN_HWC1_LONG = 4'hE;
  localparam logic [3:0] GOCX_IN_HWC2_LONG = 4'hF;

  // Interrupt status bits
  localparam int GOCX_IRQ_PIN1 = 0;
  localparam int GOCX_IRQ_PIN2 = 1;
  localparam int GOCX_IRQ_XVALID = 2;

  // Decoded pin configuration
  typedef struct packed {
    logic       direction_in;
    logic [1:0] pull_select;
    logic       irq_edge_mode;
    logic       polarity;
    logic       drive_enable;
    logic [3:0] function_select;
  } gocx_pincfg_type;

  // Internal signal sources offered to an output pin
  typedef struct packed {
    logic level;
    logic slow_clk;
    logic on_state;
    logic sleep_state;
    logic state_change;
    logic dvs1_done;
    logic dvs2_done;
    logic epe1;
    logic epe2;
    logic system_supply_good;
    logic converter_power_good;
    logic fast_clk;
    logic aux_reset;
  } gocx_src_type;

  // Control inputs delivered from a pin
  typedef struct packed {
    logic hwc1;
    logic hwc2;
    logic hwc1_long;
    logic hwc2_long;
  } gocx_hwc_type;

  // Field extraction used by every pin
  function automatic gocx_pincfg_type gocx_decode(input logic [15:0] r);
    gocx_pincfg_type c;
    c.direction_in    = r[GOCX_POS_DIR];
    c.pull_select     = r[GOCX_POS_PULL +: 2];
    c.irq_edge_mode   = r[GOCX_POS_IRQM];
    c.polarity        = r[GOCX_POS_POL];
    c.drive_enable    = r[GOCX_POS_ENA];
    c.function_select = r[GOCX_POS_FN +: 4];
    return c;
  endfunction

endpackage

// [core/gocx_pin.sv]
// One configurable pin: function mux, polarity, tri-state and edge detect
`timescale 1ns/1ns
module gocx_pin
  import gocx_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  // Configuration and sources
  input  wire gocx_pincfg_type cfg_i,
  input  wire gocx_src_type    src_i,
  input  wire logic            pin_sync_i,
  // Pin drive
  output logic                 pin_o,
  output logic                 pin_oe_o,
  output logic                 pull_up_o,
  output logic                 pull_down_o,
  // Results
  output gocx_hwc_type         hwc_o,
  output logic                 edge_o
);

  typedef struct packed {
    logic pout;
    logic prev;
  } gocx_pinst_type;

  gocx_pinst_type s_q;
  gocx_pinst_type s_d;
  logic           src_sel;
  logic           active;

  // Output function table, reserved codes select a low source level
  always_comb
  begin
    case (cfg_i.function_select)
      GOCX_FN_LEVEL:   src_sel = src_i.level; // RL2
      GOCX_FN_SLOWCLK: src_sel = src_i.slow_clk; // RL2
      GOCX_FN_ON:      src_sel = src_i.on_state; // RL3
      GOCX_FN_SLEEP:   src_sel = src_i.sleep_state; // RL3
      GOCX_FN_CHANGE:  src_sel = src_i.state_change; // RL3
      GOCX_FN_DVS1:    src_sel = src_i.dvs1_done; // RL4
      GOCX_FN_DVS2:    src_sel = src_i.dvs2_done; // RL4
      GOCX_FN_EPE1:    src_sel = src_i.epe1; // RL4
      GOCX_FN_EPE2:    src_sel = src_i.epe2; // RL4
      GOCX_FN_SYSGOOD: src_sel = src_i.system_supply_good; // RL5
      GOCX_FN_PWRGOOD: src_sel = src_i.converter_power_good; // RL5
      GOCX_FN_FASTCLK: src_sel = src_i.fast_clk; // RL6
      GOCX_FN_AUXRST:  src_sel = src_i.aux_reset; // RL6
      default:         src_sel = 1'b0; // RL3
    endcase
  end

  // Logical level after polarity; 0 means active low
  assign active = cfg_i.polarity ? pin_sync_i : ~pin_sync_i; // RL15

  // Registered pin level and edge history
  always_comb
  begin
    s_d      = s_q;
    s_d.pout = cfg_i.polarity ? src_sel : ~src_sel; // RL15
    s_d.prev = pin_sync_i;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  // Drive only as output and only when enabled
  assign pin_o    = s_q.pout;
  assign pin_oe_o = cfg_i.drive_enable & ~cfg_i.direction_in; // RL16 RL12
  assign pull_up_o   = (cfg_i.pull_select == 2'h2); // RL13
  assign pull_down_o = (cfg_i.pull_select == GOCX_PULL_DOWN); // RL13

  // Input table applies only when the pin is an input and enabled
  always_comb
  begin
    hwc_o = '0;
    if (cfg_i.direction_in && cfg_i.drive_enable) // RL17
    begin
      hwc_o.hwc1      = active && cfg_i.function_select == GOCX_IN_HWC1;
      hwc_o.hwc2      = active && cfg_i.function_select == GOCX_IN_HWC2;      // RL1
      hwc_o.hwc1_long = active && cfg_i.function_select == GOCX_IN_HWC1_LONG; // RL1
      hwc_o.hwc2_long = active && cfg_i.function_select == GOCX_IN_HWC2_LONG; // RL1
    end
  end

  // Rising edge of the active level, or either edge in both-edge mode
  assign edge_o = cfg_i.direction_in && cfg_i.drive_enable &&
                  (cfg_i.irq_edge_mode ? (pin_sync_i != s_q.prev)
                   : (cfg_i.polarity ? (pin_sync_i & ~s_q.prev) : (~pin_sync_i & s_q.prev))); // RL14

endmodule

// [core/gocx_xtal.sv]
// Crystal run control, start-up timer and clock output selection
`timescale 1ns/1ns
module gocx_xtal
  import gocx_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  // Settings and state
  input  wire logic            osc_enable_i,
  input  wire logic            backup_enable_i,
  input  wire logic            inhibit_i,
  input  wire gocx_pstate_type pstate_i,
  input  wire logic            xtal_clk_i,
  input  wire logic            rc_clk_i,
  // Results
  output logic                 xtal_run_o,
  output logic                 xtal_valid_o,
  output logic                 clock_output_pin_o,
  output logic                 on_allowed_o
);

  typedef struct packed {
    logic [15:0] cnt;
    logic        valid;
    logic        clk;
  } gocx_xst_type;

  gocx_xst_type s_q;
  gocx_xst_type s_d;
  logic         run;

  // BACKUP state follows its own enable
  assign run = (pstate_i == GOCX_ST_BACKUP) ? backup_enable_i : osc_enable_i; // RL8 RL7

  // Settle counter; valid once stable, dropped when stopped
  always_comb
  begin
    s_d = s_q;
    if (!run)
    begin
      s_d.cnt   = '0;
      s_d.valid = 1'b0;
    end
    else if (s_q.cnt == 16'(GOCX_XTAL_SETTLE_CYC - 1))
      s_d.valid = 1'b1; // RL18
    else
      s_d.cnt = s_q.cnt + 16'h0001;
    // Glitch risk at switchover accepted; output is registered
    s_d.clk = s_q.valid ? xtal_clk_i : (inhibit_i ? 1'b0 : rc_clk_i); // RL10
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign xtal_run_o         = run;
  assign xtal_valid_o       = s_q.valid;
  assign clock_output_pin_o = s_q.clk;
  assign on_allowed_o       = ~inhibit_i | s_q.valid; // RL11

endmodule

// [core/gocx_top.sv]
// Two start-up pins and crystal control behind an Avalon-MM slave
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ns
module gocx_top
  import gocx_pkg::*;
(
  // Clock and reset
  input  wire logic            clk_i,
  input  wire logic            rst_n_i,
  // Avalon-MM slave
  input  wire logic [17:0]     avs_address_i,
  input  wire logic            avs_read_i,
  input  wire logic            avs_write_i,
  input  wire logic [31:0]     avs_writedata_i,
  input  wire logic [3:0]      avs_byteenable_i,
  output logic [31:0]          avs_readdata_o,
  output logic                 avs_waitrequest_o,
  output logic [1:0]           avs_response_o,
  output logic                 irq_o,
  // Configuration load
  input  wire logic            external_config_load_i,
  // Power state and sources
  input  wire gocx_pstate_type pstate_i,
  input  wire gocx_src_type    src1_i,
  input  wire gocx_src_type    src2_i,
  // Oscillators
  input  wire logic            xtal_clk_i,
  input  wire logic            rc_clk_i,
  output logic                 xtal_run_o,
  output logic                 xtal_valid_o,
  output logic                 clock_output_pin_o,
  output logic                 on_allowed_o,
  // Pins
  input  wire logic [1:0]      pin_i,
  output logic [1:0]           pin_o,
  output logic [1:0]           pin_oe_o,
  output logic [1:0]           pull_up_o,
  output logic [1:0]           pull_down_o,
  // Control inputs from pins
  output gocx_hwc_type         hwc_o
);

  typedef struct packed {
    logic [15:0] pin1;
    logic [15:0] pin2;
    logic [2:0]  stat;
    logic [2:0]  mask;
    logic [1:0]  sync1;
    logic [1:0]  sync2;
    logic        valid_prev;
    logic        ack;
    logic [31:0] rdata;
    logic [1:0]  resp;
  } gocx_st_type;

  gocx_st_type     s_q;
  gocx_st_type     s_d;
  gocx_pincfg_type cfg [2];
  gocx_hwc_type    hwc [2];
  gocx_src_type    src [2];
  logic [1:0]      pin_edge;
  logic [15:0]     idx;
  logic            req;
  logic            loading;

  // Word index from byte address
  assign idx     = avs_address_i[17:2];
  assign req     = (avs_read_i | avs_write_i) & ~s_q.ack;
  assign loading = external_config_load_i;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] gocx_merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] be);
    gocx_merge = old;
    if (be[0])
      gocx_merge[7:0] = wd[7:0];
    if (be[1])
      gocx_merge[15:8] = wd[15:8];
  endfunction

  // Clock dividers for the pin clock functions
  logic [7:0] fast_cnt_q;
  logic [7:0] slow_cnt_q;
  logic       fast_q;
  logic       slow_q;

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      fast_cnt_q <= 8'h00;
      slow_cnt_q <= 8'h00;
      fast_q     <= 1'b0;
      slow_q     <= 1'b0;
    end
    else
    begin
      fast_cnt_q <= (fast_cnt_q == 8'(GOCX_FAST_HALF - 1)) ? 8'h00 : fast_cnt_q + 8'h01;
      slow_cnt_q <= (slow_cnt_q == 8'(GOCX_SLOW_HALF - 1)) ? 8'h00 : slow_cnt_q + 8'h01;
      if (fast_cnt_q == 8'(GOCX_FAST_HALF - 1))
        fast_q <= ~fast_q;
      if (slow_cnt_q == 8'(GOCX_SLOW_HALF - 1))
        slow_q <= ~slow_q;
    end
  end

  // Sources per pin with the generated clocks substituted
  always_comb
  begin
    src[0]          = src1_i;
    src[1]          = src2_i;
    src[0].fast_clk = fast_q; // RL6
    src[1].fast_clk = fast_q;
    src[0].slow_clk = slow_q; // RL2
    src[1].slow_clk = slow_q;
  end

  assign cfg[0] = gocx_decode(s_q.pin1);
  assign cfg[1] = gocx_decode(s_q.pin2); // RL12 RL13 RL14

  // Two identical pins
  genvar g;
  generate
    for (g = 0; g < 2; g++)
    begin : g_pin
      gocx_pin u_pin (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .cfg_i       (cfg[g]),
        .src_i       (src[g]),
        .pin_sync_i  (g == 0 ? s_q.sync1[1] : s_q.sync2[1]),
        .pin_o       (pin_o[g]),
        .pin_oe_o    (pin_oe_o[g]),
        .pull_up_o   (pull_up_o[g]),
        .pull_down_o (pull_down_o[g]),
        .hwc_o       (hwc[g]),
        .edge_o      (pin_edge[g])
      );
    end
  endgenerate

  assign hwc_o = hwc[0] | hwc[1]; // RL1

  // Crystal control reads pin 1 crystal fields
  gocx_xtal u_xtal (
    .clk_i              (clk_i),
    .rst_n_i            (rst_n_i),
    .osc_enable_i       (s_q.pin1[GOCX_POS_XENA]),
    .backup_enable_i    (s_q.pin1[GOCX_POS_BKUP]),
    .inhibit_i          (s_q.pin1[GOCX_POS_XINH]),
    .pstate_i           (pstate_i),
    .xtal_clk_i         (xtal_clk_i),
    .rc_clk_i           (rc_clk_i),
    .xtal_run_o         (xtal_run_o),
    .xtal_valid_o       (xtal_valid_o),
    .clock_output_pin_o (clock_output_pin_o),
    .on_allowed_o       (on_allowed_o)
  );

  // Register file, interrupt status and bus answer
  always_comb
  begin
    s_d            = s_q;
    s_d.sync1      = {s_q.sync1[0], pin_i[0]};
    s_d.sync2      = {s_q.sync2[0], pin_i[1]};
    s_d.valid_prev = xtal_valid_o;
    s_d.ack        = req;
    // Events set sticky bits
    if (pin_edge[0])
      s_d.stat[GOCX_IRQ_PIN1] = 1'b1;
    if (pin_edge[1])
      s_d.stat[GOCX_IRQ_PIN2] = 1'b1;
    if (xtal_valid_o && !s_q.valid_prev)
      s_d.stat[GOCX_IRQ_XVALID] = 1'b1;
    if (req)
    begin
      s_d.rdata = 32'h0000_0000;
      s_d.resp  = 2'h0;
      case (idx)
        GOCX_IDX_PIN1:
        begin
          s_d.rdata[15:0] = s_q.pin1;
          if (avs_write_i)
          begin
            s_d.pin1 = gocx_merge(s_q.pin1, avs_writedata_i, avs_byteenable_i);
            // Crystal fields locked outside a load
            if (!loading)
              s_d.pin1[2:0] = s_q.pin1[2:0]; // RL9
          end
        end
        GOCX_IDX_PIN2:
        begin
          s_d.rdata[15:0] = s_q.pin2;
          if (avs_write_i)
            s_d.pin2 = gocx_merge(s_q.pin2, avs_writedata_i, avs_byteenable_i);
        end
        GOCX_IDX_STAT:
        begin
          s_d.rdata[2:0] = s_q.stat;
          // Read clears, but an event in the same cycle survives
          if (avs_read_i)
            s_d.stat = {xtal_valid_o && !s_q.valid_prev, pin_edge};
        end
        GOCX_IDX_MASK:
        begin
          s_d.rdata[2:0] = s_q.mask;
          if (avs_write_i && avs_byteenable_i[0])
            s_d.mask = avs_writedata_i[2:0];
        end
        GOCX_IDX_CTRL:
          s_d.rdata[0] = loading;
        GOCX_IDX_STATE:
          s_d.rdata[3:0] = {xtal_valid_o, on_allowed_o, pstate_i};
        default:
          s_d.resp = 2'h2;
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i)
    begin
      s_q      <= '0;
      s_q.pin1 <= {GOCX_RST_PIN[15:3], GOCX_RST_XTAL}; // RL7 RL10
      s_q.pin2 <= GOCX_RST_PIN; // RL12 RL13 RL15 RL16
    end
    else
      s_q <= s_d;
  end

  // One wait cycle, answer on the second edge
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~s_q.ack;
  assign avs_readdata_o    = s_q.rdata;
  assign avs_response_o    = s_q.resp;
  assign irq_o             = |(s_q.stat & s_q.mask);

endmodule

// [dv/gocx_monitor.sv]
// Checker for the pin and crystal block
`timescale 1ns/1ns
module gocx_monitor
  import gocx_pkg::*;
(
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_n_i,
  input wire logic [17:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic        avs_waitrequest_o,
  input wire logic [1:0]  avs_response_o,
  // Crystal and pins
  input wire logic        xtal_run_o,
  input wire logic        xtal_valid_o,
  input wire logic        clock_output_pin_o,
  input wire logic        on_allowed_o,
  input wire logic [1:0]  pin_oe_o,
  input wire logic [1:0]  pull_up_o,
  input wire logic [1:0]  pull_down_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [15:0] run_q;
  logic        req;
  logic        mapped;
  // Request decode
  assign req = avs_read_i | avs_write_i;
  assign mapped = (avs_address_i[17:2] >= GOCX_IDX_PIN1) && (avs_address_i[17:2] <= GOCX_IDX_STATE);
  // Run length; saturates so a long run never wraps to a small count
  always_ff @(posedge clk_i)
  begin
    if (!rst_n_i || !xtal_run_o)
      run_q <= 16'h0;
    else if (run_q != 16'hFFFF)
      run_q <= run_q + 16'h1;
  end
  wait_one_a: assert property (req && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("no answer after one wait");
  idle_nowait_a: assert property (!req |-> !avs_waitrequest_o)
    else $error("wait with no request");
  bad_addr_a: assert property (req && avs_waitrequest_o && !mapped |=> avs_response_o == 2'h2)
    else $error("unmapped access not refused");
  good_addr_a: assert property (req && avs_waitrequest_o && mapped |=> avs_response_o == 2'h0)
    else $error("mapped access refused");
  valid_after_a: assert property ($rose(xtal_valid_o) |-> run_q + 2 >= GOCX_XTAL_SETTLE_CYC &&
    run_q <= GOCX_XTAL_SETTLE_CYC + 3) else $error("crystal valid at wrong time");
  valid_late_a: assert property (run_q == GOCX_XTAL_SETTLE_CYC + 4 |-> xtal_valid_o)
    else $error("crystal not valid");
  valid_drop_a: assert property (!xtal_run_o |=> !xtal_valid_o)
    else $error("valid while stopped");
  on_gate_a: assert property (xtal_valid_o |-> on_allowed_o)
    else $error("ON held while crystal valid");
  clk_hold_a: assert property (!on_allowed_o [*3] |-> !clock_output_pin_o)
    else $error("clock output while held");
  pull_excl_a: assert property ((pull_up_o & pull_down_o) == 2'h0)
    else $error("pull-up and pull-down together");
  reset_pins_a: assert property ($rose(rst_n_i) |-> pull_down_o == 2'h3 && pin_oe_o == 2'h0)
    else $error("pins not idle after reset");
  // Main scenarios reached
  cover property (req && avs_waitrequest_o && !mapped);
  cover property ($rose(xtal_valid_o));
  cover property ($fell(xtal_valid_o));
endmodule

bind gocx_top gocx_monitor gocx_monitor_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
  .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_waitrequest_o(avs_waitrequest_o),
  .avs_response_o(avs_response_o), .xtal_run_o(xtal_run_o), .xtal_valid_o(xtal_valid_o),
  .clock_output_pin_o(clock_output_pin_o), .on_allowed_o(on_allowed_o), .pin_oe_o(pin_oe_o),
  .pull_up_o(pull_up_o), .pull_down_o(pull_down_o));

// [dv/gocx_board.sv]
// Board side model: two pin wires and both oscillators
`timescale 1ns/1ns
module gocx_board
(
  // Clock
  input wire logic       clk_i,
  // Design drive
  input wire logic [1:0] pin_o,
  input wire logic [1:0] pin_oe_o,
  input wire logic [1:0] pull_up_o,
  input wire logic [1:0] pull_down_o,
  input wire logic       xtal_run_o,
  // Bench drive of the pins
  input wire logic [1:0] drv_en_i,
  input wire logic [1:0] drv_val_i,
  // To the design
  output logic [1:0]     pin_i,
  output logic           xtal_clk_o,
  output logic           rc_clk_o
);
  logic [2:0] div_q = 3'h0;
  logic       junk_q = 1'b0;
  // Oscillators; the crystal stands still while not running
  always @(posedge clk_i)
  begin
    div_q <= div_q + 3'h1;
    junk_q <= ~junk_q;
    rc_clk_o <= div_q[1];
    xtal_clk_o <= xtal_run_o & div_q[2];
  end
  // Wire level; an undriven pin without pull wanders every cycle
  always_comb
    for (int i = 0; i < 2; i++)
      pin_i[i] = pin_oe_o[i] ? pin_o[i] : drv_en_i[i] ? drv_val_i[i] : pull_up_o[i] | (~pull_down_o[i] & junk_q);
endmodule

// [dv/tb_top.sv]
// Bench for the pin and crystal block
`timescale 1ns/1ns
module tb_top
  import gocx_pkg::*;
;
  logic            clk_i = 1'b0;
  logic            rst_n_i = 1'b0;
  logic [17:0]     avs_address_i = 18'h0;
  logic            avs_read_i = 1'b0;
  logic            avs_write_i = 1'b0;
  logic [31:0]     avs_writedata_i = 32'h0;
  logic            load_i = 1'b0;
  gocx_pstate_type pstate_i = GOCX_ST_OFF;
  gocx_src_type    src2_i = '0;
  logic [1:0]      drv_en = 2'h3, drv_val = 2'h0;
  logic [1:0]      resp, rs, pin_o, pin_oe_o, pull_up_o, pull_down_o, pin_i;
  logic            waitreq, irq_o, xtal_run_o, xtal_valid_o, clk_out, on_allowed_o, xtal_clk, rc_clk;
  gocx_hwc_type    hwc_o;
  logic [31:0]     rdata;
  logic [15:0]     rd;
  int              errors = 0, compares = 0, n, h;
  int              bitpos [16] = '{12, 11, 10, 9, 8, -1, -1, -1, 7, 6, 5, 4, 3, 2, 1, 0};
  logic [15:0]     ecfg [3] = '{16'h8510, 16'h8110, 16'h9510};
  logic [15:0]     erise [3] = '{16'h2, 16'h0, 16'h2};
  logic [15:0]     efall [3] = '{16'h0, 16'h2, 16'h2};

  always #50 clk_i = ~clk_i;

  gocx_top gocx_top_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .avs_response_o(resp),
    .irq_o(irq_o), .external_config_load_i(load_i), .pstate_i(pstate_i), .src1_i('0), .src2_i(src2_i),
    .xtal_clk_i(xtal_clk), .rc_clk_i(rc_clk), .xtal_run_o(xtal_run_o), .xtal_valid_o(xtal_valid_o),
    .clock_output_pin_o(clk_out), .on_allowed_o(on_allowed_o), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o), .pull_down_o(pull_down_o), .hwc_o(hwc_o));

  gocx_board gocx_board_inst (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_o(pin_oe_o), .pull_up_o(pull_up_o),
    .pull_down_o(pull_down_o), .xtal_run_o(xtal_run_o), .drv_en_i(drv_en), .drv_val_i(drv_val),
    .pin_i(pin_i), .xtal_clk_o(xtal_clk), .rc_clk_o(rc_clk));

  task automatic conclude();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask

  // One transfer, held until waitrequest is seen low at an edge
  task automatic xfer(input logic wr, input logic [15:0] idx, input logic [15:0] wd);
    int k;
    k = 0;
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {16'h0, wd};
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do
    begin
      @(posedge clk_i);
      k++;
    end
    while (waitreq !== 1'b0 && k < 20);
    rd = rdata[15:0];
    rs = resp;
    if (k >= 20)
    begin
      errors++;
      conclude();
    end
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rdchk(input logic [15:0] idx, input logic [15:0] e, input string nm);
    xfer(1'b0, idx, 16'h0);
    chk(nm, e, rd);
  endtask

  // Level changes of clock output or pin 2
  task automatic count(input bit sel, input int cyc, output int t);
    logic p;
    logic v;
    t = 0;
    p = sel ? pin_o[1] : clk_out;
    repeat (cyc)
    begin
      @(posedge clk_i);
      v = sel ? pin_o[1] : clk_out;
      t += (v !== p);
      p = v;
    end
  endtask

  task automatic load(input logic [15:0] v);
    load_i <= 1'b1;
    xfer(1'b1, GOCX_IDX_PIN1, v);
    load_i <= 1'b0;
  endtask

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rdchk(GOCX_IDX_PIN1, 16'hA400, "pin1 reset");
    rdchk(GOCX_IDX_PIN2, 16'hA400, "pin2 reset");
    chk("pull down", 2'h3, pull_down_o);
    xfer(1'b0, 16'h7820, 16'h0);
    chk("unmapped resp", 2'h2, rs);
    // Output functions, one source moved at a time
    drv_en <= 2'h1;
    for (int c = 0; c < 16; c++)
    begin
      xfer(1'b1, GOCX_IDX_PIN2, 16'h0500 | 16'(c << 4));
      chk("pin driven", 1, pin_oe_o[1]);
      h = (c == 1) ? GOCX_SLOW_HALF : GOCX_FAST_HALF;
      if (c == 1 || c == 14)
      begin
        count(1'b1, 20 * h, n);
        chk("clock function", 1, n >= 20 * h / (h + 1) && n <= 21);
      end
      else
      begin
        src2_i <= (bitpos[c] < 0) ? '1 : 13'(1 << bitpos[c]);
        repeat (3) @(posedge clk_i);
        chk("source high", bitpos[c] >= 0, pin_o[1]);
        src2_i <= (bitpos[c] < 0) ? '0 : ~13'(1 << bitpos[c]);
        repeat (3) @(posedge clk_i);
        chk("source low", 0, pin_o[1]);
      end
    end
    xfer(1'b1, GOCX_IDX_PIN2, 16'h0100);
    src2_i <= 13'h1000;
    repeat (3) @(posedge clk_i);
    chk("inverted level", 0, pin_o[1]);
    xfer(1'b1, GOCX_IDX_PIN2, 16'h0400);
    chk("tri-stated", 0, pin_oe_o[1]);
    drv_en <= 2'h3;
    // Input functions reach the control inputs
    for (int c = 12; c < 16; c++)
    begin
      xfer(1'b1, GOCX_IDX_PIN2, 16'h8500 | 16'(c << 4));
      drv_val <= 2'h2;
      repeat (4) @(posedge clk_i);
      chk("control input", 4'h8 >> (c - 12), hwc_o);
      chk("input not driven", 0, pin_oe_o[1]);
      drv_val <= 2'h0;
      repeat (4) @(posedge clk_i);
    end
    // Edge modes against polarity
    xfer(1'b1, GOCX_IDX_MASK, 16'h7);
    for (int k = 0; k < 3; k++)
    begin
      xfer(1'b1, GOCX_IDX_PIN2, ecfg[k]);
      xfer(1'b0, GOCX_IDX_STAT, 16'h0);
      drv_val <= 2'h2;
      repeat (4) @(posedge clk_i);
      chk("irq on rise", erise[k] != 0, irq_o);
      rdchk(GOCX_IDX_STAT, erise[k], "rise event");
      drv_val <= 2'h0;
      repeat (4) @(posedge clk_i);
      rdchk(GOCX_IDX_STAT, efall[k], "fall event");
    end
    xfer(1'b1, GOCX_IDX_MASK, 16'h0);
    drv_val <= 2'h2;
    repeat (4) @(posedge clk_i);
    chk("masked irq", 0, irq_o);
    rdchk(GOCX_IDX_STAT, 16'h2, "masked event");
    // Crystal control
    xfer(1'b1, GOCX_IDX_MASK, 16'h7);
    xfer(1'b1, GOCX_IDX_PIN1, 16'hA407);
    rdchk(GOCX_IDX_PIN1, 16'hA400, "crystal bits locked");
    load(16'hA406);
    rdchk(GOCX_IDX_PIN1, 16'hA406, "crystal bits loaded");
    chk("run in OFF", 1, xtal_run_o);
    pstate_i <= GOCX_ST_SLEEP;
    @(posedge clk_i);
    chk("run in SLEEP", 1, xtal_run_o);
    pstate_i <= GOCX_ST_BACKUP;
    @(posedge clk_i);
    chk("run in BACKUP", 0, xtal_run_o);
    pstate_i <= GOCX_ST_ON;
    @(posedge clk_i);
    chk("ON held", 0, on_allowed_o);
    count(1'b0, 40, n);
    chk("clock held low", 0, n);
    n = 40;
    while (xtal_valid_o !== 1'b1 && n < 12000)
    begin
      @(posedge clk_i);
      n++;
    end
    chk("settle time", 1, n + 4 >= GOCX_XTAL_SETTLE_CYC && n < 12000);
    chk("ON allowed", 1, on_allowed_o);
    @(posedge clk_i);
    chk("valid irq", 1, irq_o);
    rdchk(GOCX_IDX_STAT, 16'h4, "valid event");
    count(1'b0, 40, n);
    chk("crystal clock out", 1, n >= 8 && n <= 11);
    load(16'hA404);
    pstate_i <= GOCX_ST_BACKUP;
    @(posedge clk_i);
    pstate_i <= GOCX_ST_ON;
    @(posedge clk_i);
    chk("valid dropped", 0, xtal_valid_o);
    chk("ON not held", 1, on_allowed_o);
    count(1'b0, 40, n);
    chk("rc clock out", 1, n >= 18 && n <= 21);
    load(16'hA400);
    chk("crystal off", 0, xtal_run_o);
    conclude();
  end
endmodule
